// file: bench/spi_port_mode_and_start_control_test.sv
module spi_port_mode_and_start_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import spmsc_pkg::*;
  logic        clk = 0, link_clk = 0, srst = 1, wr = 0, rd = 0, ce = 1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] tx = 16'h0, rx = 16'h0;
  logic        port_en, controller_mode, three_wire, busy;
  logic [3:0]  ss_o, ss_oe, ss_i, drv = 4'h0;
  int          n_mismatch = 0, n_checks = 0, act = 0;
  always #20 clk = ~clk;
  always #16 link_clk = ~link_clk;
  always @(posedge link_clk) if (ss_o !== 4'h0) act <= act + 1;
  spmsc_top i_spmsc_top (.clk, .srst, .ce, .addr, .wdata, .wr, .rd, .rdata, .tx_char_count(tx),
    .rx_char_count(rx), .port_en, .controller_mode, .three_wire, .busy, .link_clk, .ss_o, .ss_oe, .ss_i);
  spmsc_peer i_spmsc_peer (.ss_o, .ss_oe, .drv, .ss_i);
  // ==========
  // bus tasks
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    // let the registered outputs settle before anyone looks at them
    #1;
  endtask : wr_reg
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask : rd_chk
  function automatic int exp_len(logic tw, int t, int r);
    int l = tw ? t + r : t;
    return (l < 1) ? 1 : l;
  endfunction : exp_len
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // one controller transaction, waits for it to finish before returning
  task automatic run(logic tw, logic hold);
    logic [3:0]  m;
    logic [31:0] c;
    m = 4'($urandom_range(15, 1));
    c = {12'h0, m, 7'h0, hold, 8'h03};
    tx <= 16'($urandom_range(6));
    rx <= 16'($urandom_range(6));
    wr_reg(OFF_MODE, 32'(tw) << 15);
    wr_reg(OFF_CTRL, c);
    act = 0;
    wr_reg(OFF_CTRL, c | 32'h20);
    chk("oe", ss_oe, 4'hf);
    rd_chk("busy", OFF_CTRL, c | 32'h20);
    for (int n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk);
    if (!hold) chk("len", act, exp_len(tw, tx, rx));
    chk("ss", ss_o, hold ? m : 4'h0);
    rd_chk("done", OFF_CTRL, c);
  endtask : run
  // ==========
  // main sequence
  initial begin
    void'($urandom(45));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_chk("ctrl", OFF_CTRL, 32'h0);
    rd_chk("pkt0", OFF_PKT_SIZE, 32'h0);
    wr_reg(OFF_CTRL, 32'h21);
    rd_chk("deny", OFF_CTRL, 32'h1);
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    chk("tw", three_wire, 1'b1);
    run(1'b1, 1'b1);
    rd_chk("pkt", OFF_PKT_SIZE, {rx, tx});
    wr_reg(OFF_CTRL, 32'h0005_0112);
    rd_chk("off", OFF_CTRL, 32'h0005_0112);
    chk("en", port_en, 1'b0);
    wr_reg(OFF_CTRL, 32'h13);
    drv <= 4'($urandom);
    chk("dir", ss_oe, 4'h0);
    repeat (4) @(posedge clk);
    rd_chk("stat", OFF_STATUS, {24'h0, drv, 4'h0});
    rd_chk("hole", 8'h20, 32'h0);
    wr_reg(OFF_CTRL, 32'h1);
    chk("role", controller_mode, 1'b0);
    print_verdict();
  end
  initial begin
    #200us;
    n_mismatch++;
    print_verdict();
  end
endmodule : spi_port_mode_and_start_control_test

// file: bench/spmsc_assertions.sv
module spmsc_checker (
  input wire logic                         clk, srst, ce, wr, rd, port_en, controller_mode, three_wire, busy,
  input wire logic [spmsc_pkg::ADDR_W-1:0] addr,
  input wire logic [spmsc_pkg::DATA_W-1:0] wdata, rdata,
  input wire logic [spmsc_pkg::CNT_W-1:0]  tx_char_count, rx_char_count,
  input wire logic [spmsc_pkg::SS_N-1:0]   ss_oe
);
  import spmsc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ctrl_wr; wr && ce && addr == OFF_CTRL; endsequence
  sequence s_go; s_ctrl_wr ##0 wdata[BIT_START]; endsequence
  sequence s_rd(a); rd && ce && addr == a; endsequence
  a_start_go: assert property (s_go ##0 (port_en && controller_mode && !busy) |=> busy)
    else $error("start not taken");
  a_start_deny: assert property (s_go ##0 !(port_en && controller_mode) && !busy |=> !busy)
    else $error("start taken outside controller role");
  a_start_read: assert property (s_rd(OFF_CTRL) |=> rdata[BIT_START] == $past(busy))
    else $error("start bit read wrong");
  a_role_write: assert property (s_ctrl_wr |=> controller_mode == $past(wdata[BIT_ROLE]))
    else $error("role not written");
  a_enable_write: assert property (s_ctrl_wr |=> port_en == $past(wdata[BIT_EN]))
    else $error("enable not written");
  a_oe_dir: assert property (s_ctrl_wr |=> ss_oe == {4{$past(wdata[0] & wdata[1] & ~wdata[4])}})
    else $error("select direction wrong");
  a_three_wire: assert property (wr && ce && addr == OFF_MODE |=> three_wire == $past(wdata[15]))
    else $error("three wire not written");
  a_pkt_read: assert property (s_rd(OFF_PKT_SIZE) ##0 !$past(srst) |=>
    rdata == {$past(rx_char_count, 2), $past(tx_char_count, 2)})
    else $error("packet size read wrong");
  a_rdata_idle: assert property (!(rd && ce) |=> rdata == 32'h0) else $error("read data not idle");
endmodule : spmsc_checker
bind spmsc_top spmsc_checker i_spmsc_checker (.clk, .srst, .ce, .wr, .rd, .port_en, .controller_mode,
  .three_wire, .busy, .addr, .wdata, .rdata, .tx_char_count, .rx_char_count, .ss_oe);

// file: bench/spmsc_peer.sv
module spmsc_peer (
  input  wire logic [3:0] ss_o,
  input  wire logic [3:0] ss_oe,
  input  wire logic [3:0] drv,
  output logic      [3:0] ss_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // device level while driven, the far side's own level otherwise
  assign ss_i = (ss_oe & ss_o) | (~ss_oe & drv);
endmodule : spmsc_peer

// file: hdl/spmsc_top.sv
module spmsc_top (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  input  wire logic [spmsc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [spmsc_pkg::DATA_W-1:0]  wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [spmsc_pkg::DATA_W-1:0]  rdata,
  input  wire logic [spmsc_pkg::CNT_W-1:0]   tx_char_count,
  input  wire logic [spmsc_pkg::CNT_W-1:0]   rx_char_count,
  output logic                               port_en,
  output logic                               controller_mode,
  output logic                               three_wire,
  output logic                               busy,
  input  wire logic                          link_clk,
  output logic      [spmsc_pkg::SS_N-1:0]    ss_o,
  output logic      [spmsc_pkg::SS_N-1:0]    ss_oe,
  input  wire logic [spmsc_pkg::SS_N-1:0]    ss_i
);
  import spmsc_pkg::*;

  // ==========================================================================
  // system domain state
  typedef struct packed {
    logic              en;
    logic              role;
    logic              ss_dir;
    logic              ss_hold;
    logic [SS_N-1:0]   ss_mask;
    logic              three_wire;
    logic              start_busy;
    logic              start_tgl;
    logic              done_meta;
    logic              done_sync;
    logic              done_prev;
    logic [LEN_W-1:0]  len;
    logic [CNT_W-1:0]  tx_cnt;
    logic [CNT_W-1:0]  rx_cnt;
    logic [SS_N-1:0]   ss_meta;
    logic [SS_N-1:0]   ss_sync;
    logic [SS_N-1:0]   ss_oe;
    logic [DATA_W-1:0] rdata;
  } spmsc_sys_t;

  // ==========================================================================
  // link domain state
  typedef struct packed {
    logic              rst_meta;
    logic              rst_sync;
    logic              start_meta;
    logic              start_sync;
    logic              start_prev;
    logic              active;
    logic [LEN_W-1:0]  remain;
    logic              done_tgl;
    logic [SS_N-1:0]   ss_drive;
  } spmsc_lnk_t;

  spmsc_sys_t sys_reg;
  spmsc_sys_t sys_next;
  spmsc_lnk_t lnk_reg;
  spmsc_lnk_t lnk_next;

  logic done_evt;
  assign done_evt = sys_reg.done_sync ^ sys_reg.done_prev;

  // ==========================================================================
  // system domain: registers and start control
  always_comb begin
    sys_next = sys_reg;
    sys_next.done_meta = lnk_reg.done_tgl;
    sys_next.done_sync = sys_reg.done_meta;
    sys_next.done_prev = sys_reg.done_sync;
    sys_next.ss_meta   = ss_i;
    sys_next.ss_sync   = sys_reg.ss_meta;
    sys_next.tx_cnt    = tx_char_count;
    sys_next.rx_cnt    = rx_char_count;
    sys_next.rdata     = RST_WORD;

    if (done_evt) begin
      sys_next.start_busy = 1'b0;                                    // see RULE14
    end

    if (wr && addr == OFF_CTRL) begin
      sys_next.en      = wdata[BIT_EN];                              // see RULE7
      sys_next.role    = wdata[BIT_ROLE];                            // see RULE6
      sys_next.ss_dir  = wdata[BIT_SS_DIR];
      sys_next.ss_hold = wdata[BIT_SS_HOLD];
      sys_next.ss_mask = wdata[POS_SS_MASK +: SS_N];
      // a zero written to start is ignored; a one while busy is refused
      if (wdata[BIT_START] && sys_reg.en && sys_reg.role && !sys_reg.start_busy) begin  // see RULE1 see RULE4
        sys_next.start_busy = 1'b1;                                  // see RULE2
        sys_next.start_tgl  = ~sys_reg.start_tgl;
        if (sys_reg.three_wire) begin
          sys_next.len = {1'b0, sys_reg.tx_cnt} + {1'b0, sys_reg.rx_cnt};  // see RULE13
        end else begin
          sys_next.len = {1'b0, sys_reg.tx_cnt};                     // see RULE9
        end
      end
    end
    if (wr && addr == OFF_MODE) begin
      sys_next.three_wire = wdata[BIT_THREE_WIRE];                   // see RULE13
    end

    // selects are driven only by an enabled controller with output direction
    sys_next.ss_oe = {SS_N{sys_next.en & sys_next.role & ~sys_next.ss_dir}};  // see RULE4 see RULE5

    if (rd) begin
      unique case (addr)
        OFF_CTRL: begin
          sys_next.rdata[BIT_EN]                 = sys_reg.en;
          sys_next.rdata[BIT_ROLE]               = sys_reg.role;
          sys_next.rdata[BIT_SS_DIR]             = sys_reg.ss_dir;
          sys_next.rdata[BIT_START]              = sys_reg.start_busy;  // see RULE2
          sys_next.rdata[BIT_SS_HOLD]            = sys_reg.ss_hold;
          sys_next.rdata[POS_SS_MASK +: SS_N]    = sys_reg.ss_mask;
        end
        OFF_PKT_SIZE: begin
          sys_next.rdata[0 +: CNT_W]             = sys_reg.tx_cnt;   // see RULE10
          sys_next.rdata[POS_RX_CNT +: CNT_W]    = sys_reg.rx_cnt;   // see RULE8
        end
        OFF_MODE: begin
          sys_next.rdata[BIT_THREE_WIRE]         = sys_reg.three_wire;
        end
        OFF_STATUS: begin
          sys_next.rdata[BIT_BUSY]               = sys_reg.start_busy;
          sys_next.rdata[POS_SS_PIN +: SS_N]     = sys_reg.ss_sync;
        end
        default: begin
          sys_next.rdata = RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sys_reg <= '0;
    end else if (ce) begin
      sys_reg <= sys_next;
    end
  end

  // ==========================================================================
  // link domain: select lines and character counting
  always_comb begin
    lnk_next = lnk_reg;
    lnk_next.rst_meta   = srst;
    lnk_next.rst_sync   = lnk_reg.rst_meta;
    lnk_next.start_meta = sys_reg.start_tgl;
    lnk_next.start_sync = lnk_reg.start_meta;
    lnk_next.start_prev = lnk_reg.start_sync;

    if (lnk_reg.rst_sync) begin
      lnk_next.active   = 1'b0;
      lnk_next.remain   = '0;
      lnk_next.done_tgl = 1'b0;
      lnk_next.ss_drive = '0;
      lnk_next.start_prev = 1'b0;
    end else if (lnk_reg.start_sync ^ lnk_reg.start_prev) begin
      // len stays stable in the system domain while busy; mask follows any control write
      lnk_next.active   = 1'b1;
      lnk_next.remain   = sys_reg.len;
      lnk_next.ss_drive = sys_reg.ss_mask;                           // see RULE11
    end else if (lnk_reg.active) begin
      if (lnk_reg.remain <= LEN_ONE) begin
        lnk_next.active   = 1'b0;
        lnk_next.remain   = '0;
        lnk_next.done_tgl = ~lnk_reg.done_tgl;                       // see RULE14
        if (!sys_reg.ss_hold) begin
          lnk_next.ss_drive = '0;                                    // see RULE12
        end
      end else begin
        lnk_next.remain = lnk_reg.remain - LEN_ONE;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    lnk_reg <= lnk_next;
  end

  // ==========================================================================
  // outputs
  assign rdata           = sys_reg.rdata;
  assign port_en         = sys_reg.en;
  assign controller_mode = sys_reg.role;
  assign three_wire      = sys_reg.three_wire;
  assign busy            = sys_reg.start_busy;
  assign ss_o            = lnk_reg.ss_drive;
  assign ss_oe           = sys_reg.ss_oe;

endmodule : spmsc_top

// file: shared/spmsc_pkg.sv
// Summary of operation
// RULE1 - writing one to start in controller role begins a controller transaction
// RULE2 - start reads one while a started transaction runs, zero otherwise
// RULE3 - software waits for pending transactions to finish before setting start
// RULE4 - start and select direction are ignored unless role bit is one
// RULE5 - select direction zero drives select pins, one makes them inputs
// RULE6 - role bit zero is peripheral, one is controller
// RULE7 - enable bit turns port on or off, settings stay intact when off
// RULE8 - packet size bits 31:16 report receive character count
// RULE9 - four-wire mode uses transmit count as length of both directions
// RULE10 - packet size bits 15:0 report transmit character count
// RULE11 - at start, every select line set in the four-bit mask asserts
// RULE12 - at end, selects release unless select-hold bit is one
// RULE13 - three-wire bit zero is four-wire full duplex, one is three-wire
// RULE14 - start clears itself at completion, writing zero to it does nothing
package spmsc_pkg;

  // ==========================================================================
  // bus and register map
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 16;
  localparam int          LEN_W          = 17;
  localparam int          SS_N           = 4;
  localparam logic [7:0]  OFF_CTRL       = 8'h04;
  localparam logic [7:0]  OFF_PKT_SIZE   = 8'h08;
  localparam logic [7:0]  OFF_MODE       = 8'h0c;
  localparam logic [7:0]  OFF_STATUS     = 8'h10;

  // ==========================================================================
  // field positions
  localparam int          BIT_EN         = 0;
  localparam int          BIT_ROLE       = 1;
  localparam int          BIT_SS_DIR     = 4;
  localparam int          BIT_START      = 5;
  localparam int          BIT_SS_HOLD    = 8;
  localparam int          POS_SS_MASK    = 16;
  localparam int          POS_RX_CNT     = 16;
  localparam int          BIT_THREE_WIRE = 15;
  localparam int          BIT_BUSY       = 0;
  localparam int          POS_SS_PIN     = 4;

  // ==========================================================================
  // reset values and count step
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [16:0] LEN_ONE        = 17'h0_0001;

endpackage : spmsc_pkg
